// ### hdl/apc_pkg.sv
// apc_pkg: constants and carrier types for the parallel host port and conversion control
// assumes a single 125 MHz clock domain; used by apc_top and apc_conv_seq
package apc_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int DATA_W        = 8;
	localparam int CFG_W         = 6;

	// register index carried in the two top bus bits
	localparam logic [1:0] IDX_WORD_ZERO = 2'h0;
	localparam logic [1:0] IDX_WORD_ONE  = 2'h1;

	// field positions inside control_word_zero / control_word_one
	localparam int CW0_SOFT_START_BIT = 5;
	localparam int CW0_PULSE_MODE_BIT = 4;
	localparam int CW1_TWOS_COMP_BIT  = 1;

	// self-configuration loads zeros: internal oscillator, hardware start
	localparam logic [5:0] CW_RESET_VAL = 6'h00;

	// conversion length in converter clocks
	localparam int CONV_CLOCKS = 16;
	// software start: conversion begins this many clocks after sampling
	localparam int SOFT_SAMPLE_CLOCKS = 6;

	// auto power-down delay after conversion end
	localparam int AUTO_PD_NS     = 50;
	localparam int AUTO_PD_CYCLES = (AUTO_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic       softStart;
		logic       pulseMode;
		logic       twosComp;
	} apc_cfg_t;

	typedef struct packed {
		logic [7:0] dataOut;
		logic [7:0] dataOe;
	} apc_bus_t;

endpackage

// ### hdl/apc_conv_seq.sv
// apc_conv_seq: sampling / conversion sequencer with auto power-down timer
// assumes start pulses arrive as single-cycle strobes on clk, gated by ce
`timescale 1ns/1ns
module apc_conv_seq #(
	parameter int CONV_LEN = apc_pkg::CONV_CLOCKS,
	parameter int SAMP_LEN = apc_pkg::SOFT_SAMPLE_CLOCKS
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       sampleStart,
	input  wire logic       convStart,
	input  wire logic       timedSample,
	input  wire logic [7:0] analogCode,
	output logic            sampling,
	output logic            converting,
	output logic            convEnd,
	output logic            powerDown,
	output logic [7:0]      result
);

	typedef enum logic [1:0] {APC_IDLE, APC_SAMPLE, APC_CONVERT} apc_seq_t;

	apc_seq_t    state_q, state_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [3:0]  pdCnt_q, pdCnt_d;
	logic        pd_q, pd_d;
	logic        end_q, end_d;
	logic [7:0]  res_q, res_d;

	// --------------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		end_d   = 1'b0;
		res_d   = res_q;
		case (state_q)
			APC_IDLE: begin
				if (sampleStart) begin
					state_d = APC_SAMPLE;
					cnt_d   = 5'h0;
				end
			end
			APC_SAMPLE: begin
				cnt_d = cnt_q + 5'h1;
				// timed sampling ends itself; hardware sampling waits for trigger release
				if ((timedSample && cnt_q == 5'(SAMP_LEN - 1)) || (!timedSample && convStart)) begin
					state_d = APC_CONVERT;
					cnt_d   = 5'h0;
				end
			end
			default: begin
				cnt_d = cnt_q + 5'h1;
				if (cnt_q == 5'(CONV_LEN - 1)) begin
					state_d = APC_IDLE;
					end_d   = 1'b1;
					res_d   = analogCode;
				end
			end
		endcase
	end

	// --------------------------------------------------------------------
	// auto power-down: entered a fixed delay after each conversion
	// --------------------------------------------------------------------
	always_comb begin
		pdCnt_d = pdCnt_q;
		pd_d    = pd_q;
		if (sampleStart || state_q != APC_IDLE) begin
			pd_d    = 1'b0;
			pdCnt_d = 4'h0;
		end else if (end_q) begin
			pdCnt_d = 4'(apc_pkg::AUTO_PD_CYCLES);
		end else if (pdCnt_q != 4'h0) begin
			pdCnt_d = pdCnt_q - 4'h1;
			if (pdCnt_q == 4'h1) begin
				pd_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= APC_IDLE;
			cnt_q   <= 5'h0;
			end_q   <= 1'b0;
			res_q   <= 8'h00;
			pdCnt_q <= 4'h0;
			pd_q    <= 1'b1;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			end_q   <= end_d;
			res_q   <= res_d;
			pdCnt_q <= pdCnt_d;
			pd_q    <= pd_d;
		end
	end

	assign sampling   = (state_q == APC_SAMPLE);
	assign converting = (state_q == APC_CONVERT);
	assign convEnd    = end_q;
	assign powerDown  = pd_q;
	assign result     = res_q;

	// --------------------------------------------------------------------
	// checks
	// --------------------------------------------------------------------
	property p_conv_len;
		@(posedge clk) disable iff (rst || !ce)
		// end pulse is registered, so it stands one cycle after the sixteenth converting cycle
		$rose(converting) |-> converting [*8] ##1 converting [*8] ##1 convEnd;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion not 16 clocks");

	property p_auto_pd;
		@(posedge clk) disable iff (rst)
		(convEnd && ce) ##1 (ce && !sampleStart && state_q == APC_IDLE) [*7]
			|=> powerDown;
	endproperty
	a_auto_pd: assert property (p_auto_pd) else $error("no auto power-down");

	property p_pd_clear;
		@(posedge clk) disable iff (rst)
		(ce && sampleStart) |=> !powerDown;
	endproperty
	a_pd_clear: assert property (p_pd_clear) else $error("power-down kept on start");

endmodule

// ### hdl/apc_top.sv
// apc_top: parallel host port, two control words and conversion control
// assumes host pins are synchronous to clk; bus pins come split into in/out/oe
`timescale 1ns/1ns

// Contract
// - two host-writable control words govern start mode and power behaviour; here they set start mode, flag mode and two's complement output, not power
// - with store strobe held low, a dummy fetch loads defaults
// - store strobe tied low means non-programmable, hardware configuration used
// - auto power-down follows 50 ns after each conversion
// - bus index bits select control_word_zero or control_word_one on writes
// - strobes only count while device_select_n is low
// - selected fetch falling edge starts read, result driven onto bus
// - store rising edge with select low captures bus into addressed word
// - software start: each store rising edge starts sampling; here only from idle, and each selected fetch release also starts sampling
// - hardware start: trigger fall samples, trigger rise converts
// - results are 8 bits over a three-state bidirectional bus
// - top two bits 00 or 01 pick the word, low six carry data
// - self-configuration loads zeros: internal oscillator, hardware start
// - each conversion takes 16 clocks
// - level mode: flag low during conversion; pulse mode: one pulse after
module apc_top (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       deviceSelect_n,
	input  wire logic       fetchStrobe_n,
	input  wire logic       storeStrobe_n,
	input  wire logic       sampleTrigger_n,
	input  wire logic [7:0] dataIn,
	input  wire logic [7:0] analogCode,
	output logic      [7:0] dataOut,
	output logic      [7:0] dataOe,
	output logic            conversionDoneFlag,
	output logic            autoPowerDown,
	output logic            softPowerDown,
	output logic [5:0]      controlWordZero,
	output logic [5:0]      controlWordOne
);

	logic [5:0]  cw0_q, cw0_d;
	logic [5:0]  cw1_q, cw1_d;
	logic        fetchPrev_q, storePrev_q, trigPrev_q;
	logic        reading_q, reading_d;
	logic        flag_q, flag_d;
	logic        seenStore_q, seenStore_d;
	apc_pkg::apc_bus_t bus_q, bus_d;
	apc_pkg::apc_cfg_t cfg;
	logic        fetchFall, fetchRise, storeRise, trigFall, trigRise;
	logic        sampleStart, convStart;
	logic        sampling, converting, convEnd;
	logic [7:0]  result;
	logic [1:0]  wrIdx;

	// --------------------------------------------------------------------
	// edge detection of host strobes (pins are synchronous to clk)
	// --------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fetchPrev_q <= 1'b1;
			storePrev_q <= 1'b1;
			trigPrev_q  <= 1'b1;
		end else if (ce) begin
			fetchPrev_q <= fetchStrobe_n;
			storePrev_q <= storeStrobe_n;
			trigPrev_q  <= sampleTrigger_n;
		end
	end

	assign fetchFall = fetchPrev_q && !fetchStrobe_n && !deviceSelect_n;
	assign fetchRise = !fetchPrev_q && fetchStrobe_n && !deviceSelect_n;
	assign storeRise = !storePrev_q && storeStrobe_n && !deviceSelect_n;
	assign trigFall  = trigPrev_q && !sampleTrigger_n;
	assign trigRise  = !trigPrev_q && sampleTrigger_n;
	assign wrIdx     = dataIn[7:6];

	// one driver for the whole struct, fields in declaration order
	assign cfg = {cw0_q[apc_pkg::CW0_SOFT_START_BIT],
		cw0_q[apc_pkg::CW0_PULSE_MODE_BIT],
		cw1_q[apc_pkg::CW1_TWOS_COMP_BIT]};

	// --------------------------------------------------------------------
	// control words
	// --------------------------------------------------------------------
	always_comb begin
		cw0_d       = cw0_q;
		cw1_d       = cw1_q;
		seenStore_d = seenStore_q || storeRise;
		if (storeRise) begin
			if (wrIdx == apc_pkg::IDX_WORD_ZERO) begin
				cw0_d = dataIn[5:0];
			end else if (wrIdx == apc_pkg::IDX_WORD_ONE) begin
				cw1_d = dataIn[5:0];
			end
		end else if (fetchFall && !storeStrobe_n && !seenStore_q) begin
			// store strobe held low: dummy fetch self-configures
			cw0_d = apc_pkg::CW_RESET_VAL;
			cw1_d = apc_pkg::CW_RESET_VAL;
		end
	end

	// --------------------------------------------------------------------
	// conversion starts and the done flag
	// --------------------------------------------------------------------
	always_comb begin
		sampleStart = 1'b0;
		convStart   = 1'b0;
		if (cfg.softStart) begin
			// each store rising edge and each fetch release starts sampling from idle
			sampleStart = storeRise || fetchRise;
		end else begin
			sampleStart = trigFall;
			convStart   = trigRise;
		end
	end

	always_comb begin
		flag_d = flag_q;
		if (cfg.pulseMode) begin
			flag_d = !convEnd;
		end else if (convEnd) begin
			flag_d = 1'b1;
		end else if (converting) begin
			flag_d = 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// read path and bus drivers
	// --------------------------------------------------------------------
	always_comb begin
		reading_d = reading_q;
		bus_d     = bus_q;
		if (deviceSelect_n || fetchStrobe_n) begin
			reading_d = 1'b0;
		end else if (fetchFall) begin
			reading_d = 1'b1;
		end
		// two's complement is the offset-binary code with its top bit flipped
		bus_d.dataOut = cfg.twosComp ? {~result[7], result[6:0]} : result;
		bus_d.dataOe  = reading_d ? 8'hff : 8'h00;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cw0_q       <= apc_pkg::CW_RESET_VAL;
			cw1_q       <= apc_pkg::CW_RESET_VAL;
			seenStore_q <= 1'b0;
			flag_q      <= 1'b1;
			reading_q   <= 1'b0;
			bus_q       <= '0;
		end else if (ce) begin
			cw0_q       <= cw0_d;
			cw1_q       <= cw1_d;
			seenStore_q <= seenStore_d;
			flag_q      <= flag_d;
			reading_q   <= reading_d;
			bus_q       <= bus_d;
		end
	end

	apc_conv_seq u_seq (
		.clk        (clk),
		.rst        (rst),
		.ce         (ce),
		.sampleStart(sampleStart),
		.convStart  (convStart),
		.timedSample(cfg.softStart),
		.analogCode (analogCode),
		.sampling   (sampling),
		.converting (converting),
		.convEnd    (convEnd),
		.powerDown  (autoPowerDown),
		.result     (result)
	);

	assign dataOut            = bus_q.dataOut;
	assign dataOe             = bus_q.dataOe;
	assign conversionDoneFlag = flag_q;
	assign softPowerDown      = deviceSelect_n;
	assign controlWordZero    = cw0_q;
	assign controlWordOne     = cw1_q;

	// --------------------------------------------------------------------
	// checks
	// --------------------------------------------------------------------
	property p_write_zero;
		@(posedge clk) disable iff (rst)
		(ce && storeRise && dataIn[7:6] == 2'h0) |=> controlWordZero == $past(dataIn[5:0]);
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("word zero not written");

	property p_write_one;
		@(posedge clk) disable iff (rst)
		(ce && storeRise && dataIn[7:6] == 2'h1) |=> controlWordOne == $past(dataIn[5:0]);
	endproperty
	a_write_one: assert property (p_write_one) else $error("word one not written");

	property p_no_write_unsel;
		@(posedge clk) disable iff (rst)
		(ce && deviceSelect_n) |=> $stable(controlWordZero) && $stable(controlWordOne);
	endproperty
	a_no_write_unsel: assert property (p_no_write_unsel) else $error("write while unselected");

	property p_dummy_cfg;
		@(posedge clk) disable iff (rst)
		(ce && fetchFall && !storeStrobe_n && !seenStore_q) |=>
			controlWordZero == 6'h00 && controlWordOne == 6'h00;
	endproperty
	a_dummy_cfg: assert property (p_dummy_cfg) else $error("dummy fetch no defaults");

	property p_read_drive;
		@(posedge clk) disable iff (rst)
		(ce && fetchFall) |=> dataOe == 8'hff;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read does not drive bus");

	property p_release;
		@(posedge clk) disable iff (rst)
		(ce && deviceSelect_n) |=> dataOe == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("bus driven when unselected");

	property p_soft_start;
		@(posedge clk) disable iff (rst)
		(ce && cfg.softStart && storeRise && !sampling && !converting) |=> sampling;
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("store edge no sampling");

	property p_hw_start;
		@(posedge clk) disable iff (rst)
		(ce && !cfg.softStart && trigFall && !sampling && !converting) |=> sampling;
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("trigger fall no sampling");

	property p_level_flag;
		@(posedge clk) disable iff (rst)
		(ce && !cfg.pulseMode && converting && !convEnd) |=> !conversionDoneFlag;
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("flag high in conversion");

endmodule

// ### tb/apc_host_model.sv
// apc_host_model: host side of the parallel port, strobes and hardware trigger
// assumes tasks are called by the bench; bus comes split into in/out/oe
`timescale 1ns/1ns
module apc_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] dataOut,
	input  wire logic [7:0] dataOe,
	output logic            deviceSelect_n,
	output logic            fetchStrobe_n,
	output logic            storeStrobe_n,
	output logic            sampleTrigger_n,
	output logic [7:0]      dataIn
);
	logic       hostOe = 1'b0;
	logic [7:0] hostData = 8'h00;
	logic [7:0] lastBus = 8'h00;
	initial begin
		deviceSelect_n = 1'b1;
		fetchStrobe_n = 1'b1;
		storeStrobe_n = 1'b1;
		sampleTrigger_n = 1'b1;
	end
	// an undriven bus shows the inverse of its last level, never a stale copy
	assign dataIn = (dataOe & dataOut) | (~dataOe & (hostOe ? hostData : ~lastBus));
	always_ff @(posedge clk) begin
		if (hostOe || dataOe != 8'h00) begin
			lastBus <= dataIn;
		end
	end
	task automatic storeWord(input logic [1:0] idx, input logic [5:0] val, input logic sel);
		@(posedge clk);
		deviceSelect_n <= ~sel;
		storeStrobe_n <= 1'b0;
		hostOe <= 1'b1;
		hostData <= {idx, val};
		@(posedge clk);
		storeStrobe_n <= 1'b1;
		@(posedge clk);
		hostOe <= 1'b0;
		deviceSelect_n <= 1'b1;
	endtask
	task automatic setStore(input logic lvl);
		@(posedge clk);
		storeStrobe_n <= lvl;
	endtask
	task automatic fetch(output logic [7:0] busSeen, output logic [7:0] oeSeen);
		@(posedge clk);
		deviceSelect_n <= 1'b0;
		fetchStrobe_n <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		busSeen = dataIn;
		oeSeen = dataOe;
		@(posedge clk);
		fetchStrobe_n <= 1'b1;
		@(posedge clk);
		deviceSelect_n <= 1'b1;
	endtask
	task automatic trigger(input int lowCycles);
		@(posedge clk);
		sampleTrigger_n <= 1'b0;
		repeat (lowCycles) @(posedge clk);
		sampleTrigger_n <= 1'b1;
	endtask
endmodule

// ### tb/adc_parallel_host_control_tb.sv
// adc_parallel_host_control_tb: self-checking bench for apc_top
// assumes apc_host_model plays the host; ce is held high except while tFreeze runs
`timescale 1ns/1ns
module adc_parallel_host_control_tb;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       ce = 1'b1;
	logic [7:0] analogCode = 8'h00;
	wire        selN, fetchN, storeN, trigN, flag, apd, spd;
	wire  [7:0] dIn, dOut, dOe;
	wire  [5:0] cw0, cw1;
	int         nMismatch = 0;
	int         samplesChecked = 0;
	logic [7:0] bus, oe;
	int         n, m;
	always #4 clk = ~clk;
	apc_host_model u_host (.clk(clk), .dataOut(dOut), .dataOe(dOe), .deviceSelect_n(selN),
		.fetchStrobe_n(fetchN), .storeStrobe_n(storeN), .sampleTrigger_n(trigN), .dataIn(dIn));
	apc_top u_dut (.clk(clk), .rst(rst), .ce(ce), .deviceSelect_n(selN),
		.fetchStrobe_n(fetchN), .storeStrobe_n(storeN), .sampleTrigger_n(trigN),
		.dataIn(dIn), .analogCode(analogCode), .dataOut(dOut), .dataOe(dOe),
		.conversionDoneFlag(flag), .autoPowerDown(apd), .softPowerDown(spd),
		.controlWordZero(cw0), .controlWordOne(cw1));
	// ----------------------------------------
	// shared checking
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// bounded wait on a level of one output; count is cycles waited
	task automatic waitLvl(input bit onApd, input logic lvl, output int cnt);
		cnt = 0;
		while ((onApd ? apd : flag) !== lvl) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > 200) begin
				nMismatch++;
				tally_and_finish();
			end
		end
	endtask
	task automatic doReset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic writeWord(input logic [1:0] idx, input logic [5:0] val, input logic sel);
		u_host.storeWord(idx, val, sel);
		@(posedge clk);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic tWrite();
		writeWord(2'h0, 6'h10, 1'b1);
		check("cw0", {2'h0, cw0}, 8'h10);
		writeWord(2'h1, 6'h02, 1'b1);
		check("cw1", {2'h0, cw1}, 8'h02);
		check("cw0kept", {2'h0, cw0}, 8'h10);
		writeWord(2'h2, 6'h3f, 1'b1);
		writeWord(2'h0, 6'h3f, 1'b0);
		check("cw0refused", {2'h0, cw0}, 8'h10);
		check("cw1refused", {2'h0, cw1}, 8'h02);
		writeWord(2'h0, 6'h00, 1'b1);
		writeWord(2'h1, 6'h00, 1'b1);
	endtask
	// a selected write to word zero while ce is low must leave control word zero untouched
	task automatic tFreeze();
		@(posedge clk);
		ce <= 1'b0;
		fork
			u_host.storeWord(2'h0, 6'h15, 1'b1);
			begin
				repeat (2) @(posedge clk);
				#1;
				check("spdSel", {7'h0, spd}, 8'h00);
			end
		join
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		#1;
		check("spdIdle", {7'h0, spd}, 8'h01);
		check("cw0frozen", {2'h0, cw0}, 8'h00);
	endtask
	task automatic tHwConv(input logic [7:0] code, input logic [7:0] exp);
		@(posedge clk);
		analogCode <= code;
		u_host.trigger(3);
		#1;
		check("apdCleared", {7'h0, apd}, 8'h00);
		waitLvl(1'b0, 1'b0, n);
		waitLvl(1'b0, 1'b1, m);
		check("convLen", {7'h0, (n + m >= 16 && n + m <= 19)}, 8'h01);
		waitLvl(1'b1, 1'b1, n);
		check("apdDelay", {7'h0, (n >= 6 && n <= 9)}, 8'h01);
		u_host.fetch(bus, oe);
		check("readOe", oe, 8'hff);
		check("readData", bus, exp);
		repeat (2) @(posedge clk);
		#1;
		check("oeReleased", dOe, 8'h00);
	endtask
	task automatic tPulse();
		writeWord(2'h0, 6'h10, 1'b1);
		u_host.trigger(2);
		waitLvl(1'b0, 1'b0, n);
		waitLvl(1'b0, 1'b1, m);
		check("pulseWidth", m[7:0], 8'h01);
		check("pulseLate", {7'h0, n >= 16}, 8'h01);
	endtask
	task automatic tSoft();
		// the write that selects software start does not start; the next store edge does
		writeWord(2'h0, 6'h20, 1'b1);
		writeWord(2'h0, 6'h20, 1'b1);
		waitLvl(1'b0, 1'b0, n);
		waitLvl(1'b0, 1'b1, m);
		check("softLen", {7'h0, (n + m >= 20 && n + m <= 26)}, 8'h01);
		check("softConv", m[7:0], 8'(apc_pkg::CONV_CLOCKS));
	endtask
	task automatic tHwCfg();
		u_host.setStore(1'b0);
		doReset();
		u_host.fetch(bus, oe);
		check("cfgCw0", {2'h0, cw0}, 8'h00);
		check("cfgCw1", {2'h0, cw1}, 8'h00);
		u_host.trigger(2);
		waitLvl(1'b0, 1'b0, n);
		check("cfgHwStart", {7'h0, n < 30}, 8'h01);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		doReset();
		check("rstCw0", {2'h0, cw0}, 8'h00);
		check("rstFlag", {7'h0, flag}, 8'h01);
		check("rstOe", dOe, 8'h00);
		tWrite();
		tFreeze();
		tHwConv(8'h5a, 8'h5a);
		writeWord(2'h1, 6'h02, 1'b1);
		tHwConv(8'h5a, 8'hda);
		tPulse();
		tSoft();
		tHwCfg();
		tally_and_finish();
	end
endmodule
